// *** dv/dmcr_host.sv ***
// host-side model of the serial control port master
`timescale 1ns/10ps
`default_nettype none

module dmcr_host
#(
   parameter int PH = 8           // mclk cycles per serial clock phase, at least 4
)(
   input  wire logic mclk_i,      // system clock
   input  wire logic sdo_i,       // readback data from the device
   input  wire logic sdo_oen_i,   // device drive enable, low while driving
   output var logic  sclk_o,      // serial clock, idle low between frames
   output var logic  csn_o,       // frame select, active low
   output var logic  sdi_o        // serial data towards the device
);
   wire logic sdo_line;

   // released readback line is pulled up, so stale data never shows
   assign sdo_line = sdo_oen_i ? 1'b1 : sdo_i;

   initial
   begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      sdi_o = 1'b0;
   end

   // one whole 16-bit word; every change lands on a falling mclk edge
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                       output logic [7:0] rdat);
      logic [15:0] word;
      word = {rd, addr, wdat};
      rdat = 8'h00;
      @(negedge mclk_i);
      csn_o = 1'b0;
      repeat (PH) @(negedge mclk_i);
      for (int i = 15; i >= 0; i--)
      begin
         sclk_o = 1'b0;
         sdi_o = word[i];
         repeat (PH) @(negedge mclk_i);
         // readback bits are taken just before the rise that ends each low phase
         if (rd && i < 8)
            rdat[i] = sdo_line;
         sclk_o = 1'b1;
         repeat (PH) @(negedge mclk_i);
      end
      sclk_o = 1'b0;
      repeat (PH) @(negedge mclk_i);
      csn_o = 1'b1;
      // data line is meaningless outside a frame: show the inverse of the last bit
      sdi_o = ~sdi_o;
      repeat (PH) @(negedge mclk_i);
   endtask
endmodule

`default_nettype wire

// *** dv/dmcr_regs_tb.sv ***
// self-checking bench for the dac mode-control register bank
`timescale 1ns/10ps
`default_nettype none

module dmcr_regs_tb;
   import dmcr_pkg::*;
   localparam logic [4:0] TB_ID = 5'h15;      // arbitrary identifier value
   localparam int         WD_NS = 600000;     // about twice the expected run length
   logic        mclk, resetn, zl, zr, sclk, csn, sdi, sdo, oen, wc;
   logic        ph, step, odis, bst, roll, zmute, soft_system_reset, strm, fbyp, sgl, monor, zpd, zlp, zrp;
   logic [1:0]  ats, mrate;
   logic [7:0]  mlvl, a_s, b_s, z_s, d;
   int          mismatches = 0, checks = 0, wc_half = 8, steps = 0, srsts = 0, s0;
   int unsigned seed;

   // ---------------------------------------------------------------
   // design, host model, clocks
   // ---------------------------------------------------------------
   dmcr_regs #(.PART_ID(TB_ID)) uut (.mclk_i(mclk), .resetn_i(resetn), .ctl_sclk_i(sclk),
      .ctl_csn_i(csn), .ctl_sdi_i(sdi), .word_clock_i(wc), .left_zero_det_i(zl),
      .right_zero_det_i(zr), .ctl_sdo_o(sdo), .ctl_sdo_oen_o(oen), .phase_invert_o(ph),
      .atten_step_rate_o(ats), .atten_step_o(step), .output_disable_o(odis),
      .bypass_stereo_o(bst), .rolloff_select_o(roll), .zero_mute_o(zmute),
      .soft_reset_o(soft_system_reset), .stream_mode_o(strm), .filter_bypass_o(fbyp),
      .single_channel_o(sgl), .single_channel_mode_right_o(monor), .modulator_rate_o(mrate),
      .zero_pins_data_o(zpd), .left_zero_pin_o(zlp), .right_zero_pin_o(zrp),
      .mute_level_o(mlvl));

   dmcr_host #(.PH(8)) host (.mclk_i(mclk), .sdo_i(sdo), .sdo_oen_i(oen), .sclk_o(sclk),
      .csn_o(csn), .sdi_o(sdi));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // word clock; slowed whenever the fastest modulator rate is chosen
   initial
   begin
      wc = 1'b0;
      forever
      begin
         repeat (wc_half) @(negedge mclk);
         wc = ~wc;
      end
   end

   // pulse counters: a stretched pulse counts twice
   always @(posedge mclk)
   begin
      if (step === 1'b1)
         steps++;
      if (soft_system_reset === 1'b1)
         srsts++;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   function automatic logic zf_exp(input logic det, input logic [7:0] z, input logic [7:0] b);
      return det & (b[DMCR_B_STREAM_MODE] ? (z[2:1] != 2'b00) : z[DMCR_Z_PCM_ENABLE]);
   endfunction

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      logic [7:0] junk;
      host.xfer(1'b0, a, v, junk);
      repeat (4) @(negedge mclk);
   endtask

   task automatic rd_chk(input string n, input logic [6:0] a, input logic [7:0] e);
      logic [7:0] v;
      host.xfer(1'b1, a, 8'h00, v);
      check(n, v, e);
   endtask

   // the static mode outputs against the shadow copies; pulses, mute and zero pins are checked elsewhere
   task automatic chk_out;
      check("phase", 8'(ph), 8'(a_s[DMCR_A_PHASE_INVERT]));
      check("atten_rate", 8'(ats), 8'(a_s[6:5]));
      check("out_disable", 8'(odis), 8'(a_s[DMCR_A_OUTPUT_DISABLE]));
      check("byp_stereo", 8'(bst), 8'(a_s[DMCR_A_BYPASS_STEREO]));
      check("zero_pin_data", 8'(zpd), 8'(a_s[2] & b_s[4]));
      check("rolloff", 8'(roll), 8'(a_s[DMCR_A_ROLLOFF]));
      check("stream", 8'(strm), 8'(b_s[DMCR_B_STREAM_MODE]));
      check("filt_bypass", 8'(fbyp), 8'(b_s[DMCR_B_FILTER_BYPASS]));
      check("single", 8'(sgl), 8'(b_s[DMCR_B_SINGLE_CHAN]));
      check("single_right", 8'(monor), 8'(b_s[3] & b_s[2]));
      check("mod_rate", 8'(mrate), 8'(b_s[1:0]));
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      seed = $urandom(32'hD3FCAD98);
      resetn = 1'b0;
      zl = 1'b0;
      zr = 1'b0;
      a_s = DMCR_RST_A;
      b_s = DMCR_RST_B;
      z_s = DMCR_RST_Z;
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      chk_out();
      check("mute_level", mlvl, 8'hFF);
      rd_chk("reg_a", DMCR_ADDR_MODE_A, 8'h00);
      rd_chk("reg_b", DMCR_ADDR_MODE_B, 8'h00);
      rd_chk("reg_z", DMCR_ADDR_ZF_EN, 8'h01);
      rd_chk("dev_id", DMCR_ADDR_DEV_ID, {3'h0, TB_ID});
      rd_chk("unmapped", 7'h20, 8'h00);
      wr(DMCR_ADDR_DEV_ID, 8'hFF);
      wr(DMCR_ADDR_ZF_STAT, 8'hFF);
      rd_chk("id_after_wr", DMCR_ADDR_DEV_ID, {3'h0, TB_ID});
      // random settings; every modulator rate code appears twice
      for (int i = 0; i < 8; i++)
      begin
         d = 8'($urandom());
         wr(DMCR_ADDR_MODE_A, d);
         a_s = d & DMCR_MASK_A;
         d = (8'($urandom()) & 8'hBC) | 8'(i % 4);
         if (d[1:0] == 2'b10)
            wc_half = 512;
         wr(DMCR_ADDR_MODE_B, d);
         if (d[1:0] != 2'b10)
            wc_half = 8;
         b_s = d & DMCR_MASK_B;
         d = 8'($urandom());
         wr(DMCR_ADDR_ZF_EN, d);
         z_s = d & DMCR_MASK_Z;
         chk_out();
         rd_chk("reg_a", DMCR_ADDR_MODE_A, a_s);
         rd_chk("reg_b", DMCR_ADDR_MODE_B, b_s);
         rd_chk("reg_z", DMCR_ADDR_ZF_EN, z_s);
         zl = 1'($urandom());
         zr = 1'($urandom());
         repeat (4) @(negedge mclk);
         check("left_pin", 8'(zlp), 8'(zf_exp(zl, z_s, b_s)));
         check("right_pin", 8'(zrp), 8'(zf_exp(zr, z_s, b_s)));
         rd_chk("zero_stat", DMCR_ADDR_ZF_STAT,
                {6'h0, zf_exp(zr, z_s, b_s), zf_exp(zl, z_s, b_s)});
      end
      // soft reset restores defaults and leaves no trace of itself
      wc_half = 8;
      wr(DMCR_ADDR_MODE_A, 8'hFF);
      wr(DMCR_ADDR_ZF_EN, 8'h06);
      s0 = srsts;
      wr(DMCR_ADDR_MODE_B, 8'h5D);
      check("reset_pulses", 8'(srsts - s0), 8'h01);
      a_s = DMCR_RST_A;
      b_s = DMCR_RST_B;
      z_s = DMCR_RST_Z;
      chk_out();
      rd_chk("reg_a_soft_system_reset", DMCR_ADDR_MODE_A, 8'h00);
      rd_chk("reg_b_soft_system_reset", DMCR_ADDR_MODE_B, 8'h00);
      rd_chk("reg_z_soft_system_reset", DMCR_ADDR_ZF_EN, 8'h01);
      // step pulses over 16 word clocks: a whole number of divider periods
      zl = 1'b0;
      zr = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         wr(DMCR_ADDR_MODE_A, 8'(c << 5));
         repeat (40) @(negedge mclk);
         s0 = steps;
         repeat (256) @(negedge mclk);
         check("step_count", 8'(steps - s0), 8'(16 >> c));
      end
      // random settings may have left the ramp low: let it climb back at the fastest rate
      wr(DMCR_ADDR_MODE_A, 8'h00);
      repeat (4100) @(negedge mclk);
      check("ramp_top", mlvl, 8'hFF);
      // zero-run mute: ramp, then hold; dropped in stream mode
      zl = 1'b1;
      zr = 1'b1;
      wr(DMCR_ADDR_MODE_A, 8'h01);
      repeat (160) @(negedge mclk);
      check("ramp_moving", 8'(mlvl != 8'hFF && mlvl != 8'h00), 8'h01);
      check("mute_early", 8'(zmute), 8'h00);
      repeat (4600) @(negedge mclk);
      check("ramp_end", mlvl, 8'h00);
      check("mute_on", 8'(zmute), 8'h01);
      wr(DMCR_ADDR_MODE_B, 8'h20);
      check("mute_stream", 8'(zmute), 8'h00);
      wr(DMCR_ADDR_MODE_B, 8'h00);
      zl = 1'b0;
      repeat (4) @(negedge mclk);
      check("mute_one_side", 8'(zmute), 8'h00);
      wrap_up();
   end

   // hang guard
   initial
   begin
      #(WD_NS);
      mismatches++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule

`default_nettype wire

// *** include/dmcr_pkg.sv ***
// package: register map, field positions and reset values of the dac mode-control bank
package dmcr_pkg;
   // register addresses as seen in the control word (7-bit index)
   localparam logic [6:0] DMCR_ADDR_MODE_A   = 7'h13;
   localparam logic [6:0] DMCR_ADDR_MODE_B   = 7'h14;
   localparam logic [6:0] DMCR_ADDR_ZF_EN    = 7'h15;
   localparam logic [6:0] DMCR_ADDR_ZF_STAT  = 7'h16;
   localparam logic [6:0] DMCR_ADDR_DEV_ID   = 7'h17;
   // mode_select_a field positions
   localparam int DMCR_A_PHASE_INVERT   = 7;
   localparam int DMCR_A_ATTEN_RATE_LSB = 5;
   localparam int DMCR_A_OUTPUT_DISABLE = 4;
   localparam int DMCR_A_BYPASS_STEREO  = 2;
   localparam int DMCR_A_ROLLOFF        = 1;
   localparam int DMCR_A_ZERO_RUN_MUTE  = 0;
   // mode_select_b field positions
   localparam int DMCR_B_SOFT_RESET     = 6;
   localparam int DMCR_B_STREAM_MODE    = 5;
   localparam int DMCR_B_FILTER_BYPASS  = 4;
   localparam int DMCR_B_SINGLE_CHAN    = 3;
   localparam int DMCR_B_SINGLE_CHANNEL_MODE_SELECT    = 2;
   localparam int DMCR_B_MOD_RATE_LSB   = 0;
   // zero_flag_enable field positions
   localparam int DMCR_Z_STREAM_PAT_LSB = 1;
   localparam int DMCR_Z_PCM_ENABLE     = 0;
   // writable masks; reserved bits read zero
   localparam logic [7:0] DMCR_MASK_A = 8'hF7;
   localparam logic [7:0] DMCR_MASK_B = 8'h3F;
   localparam logic [7:0] DMCR_MASK_Z = 8'h07;
   // reset values
   localparam logic [7:0] DMCR_RST_A  = 8'h00;
   localparam logic [7:0] DMCR_RST_B  = 8'h00;
   localparam logic [7:0] DMCR_RST_Z  = 8'h01;
   // serial control word length
   localparam int DMCR_WORD_BITS = 16;
   // soft mute ramp length in attenuation steps
   localparam int DMCR_MUTE_STEPS = 256;
endpackage

// *** src/dmcr_regs.sv ***
// mode-control register bank with serial control port of the stereo dac
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] bit 15 picks write (0) or read (1)
// [R2] phase invert flips both channel polarities
// [R3] rate field: step every 1,2,4,8 word clocks
// [R4] output disable forces both outputs to zero
// [R5] bypass stereo: single_channel_mode data or zero-pin pair
// [R6] rolloff select: sharp at 0, slow at 1
// [R7] zero run mute holds zero on both zero
// [R8] no zero run mute in stream mode
// [R9] soft reset bit makes one reset pulse
// [R10] stream bit enables one-bit stream mode
// [R11] filter bypass takes external filter data
// [R12] single channel mode drives both converters balanced
// [R13] single_channel_mode select left/right only when single_channel_mode
// [R14] rate field 64,32,128 times; 11 reserved
// [R15] host avoids 128x above 100 kHz
// [R16] stream mode: rate field picks bit clock
// [R17] stream zero pattern: off, even, 96h
// [R18] pcm zero flag enable, defaults to one
// [R19] zero flags read the zero pin states
// [R20] read-only registers always answer reads
// [R21] five-bit part identifier readable
// [R22] all controls reset zero, pcm enable one
// [R23] soft mute ramps through 256 steps
// [R24] reset bit self-clears; reserved reads zero
module dmcr_regs
   import dmcr_pkg::*;
#(
   parameter logic [4:0] PART_ID = 5'h0A   // arbitrary neutral identifier value
)(
   input  wire logic       mclk_i,            // system clock, 100 MHz
   input  wire logic       resetn_i,          // async reset, active low
   input  wire logic       ctl_sclk_i,        // serial control clock pin
   input  wire logic       ctl_csn_i,         // serial control select pin, active low
   input  wire logic       ctl_sdi_i,         // serial control data in pin
   input  wire logic       word_clock_i,      // word clock pin
   input  wire logic       left_zero_det_i,   // left channel zero detected (same clock)
   input  wire logic       right_zero_det_i,  // right channel zero detected (same clock)
   output logic            ctl_sdo_o,         // serial readback data
   output logic            ctl_sdo_oen_o,     // readback enable, low while driving
   output logic            phase_invert_o,    // invert both outputs
   output logic [1:0]      atten_step_rate_o, // attenuator step rate code
   output logic            atten_step_o,      // one-cycle attenuator step pulse
   output logic            output_disable_o,  // force bipolar zero level
   output logic            bypass_stereo_o,   // bypass stereo select
   output logic            rolloff_select_o,  // 1 = slow rolloff
   output logic            zero_mute_o,       // hold outputs at bipolar zero
   output logic            soft_reset_o,      // one-cycle internal reset pulse
   output logic            stream_mode_o,     // one-bit stream mode active
   output logic            filter_bypass_o,   // internal filter bypassed
   output logic            single_channel_o,  // single_channel_mode balanced operation
   output logic            single_channel_mode_right_o,      // single_channel_mode source: 1 = right
   output logic [1:0]      modulator_rate_o,  // modulator rate / stream bit clock code
   output logic            zero_pins_data_o,  // zero pins used as data inputs
   output logic            left_zero_pin_o,   // left zero flag pin
   output logic            right_zero_pin_o,  // right zero flag pin
   output logic [7:0]      mute_level_o       // soft mute ramp position, 255 = none
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] sclk_sync_q;
   logic [1:0] csn_sync_q;
   logic [1:0] sdi_sync_q;
   logic [1:0] wclk_sync_q;
   logic       sclk_last_q;
   logic       wclk_last_q;

   // two stages per pin; only stage 1 feeds logic
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sclk_sync_q <= 2'h0;
         csn_sync_q  <= 2'h3;
         sdi_sync_q  <= 2'h0;
         wclk_sync_q <= 2'h0;
         sclk_last_q <= 1'b0;
         wclk_last_q <= 1'b0;
      end
      else
      begin
         sclk_sync_q <= {sclk_sync_q[0], ctl_sclk_i};
         csn_sync_q  <= {csn_sync_q[0], ctl_csn_i};
         sdi_sync_q  <= {sdi_sync_q[0], ctl_sdi_i};
         wclk_sync_q <= {wclk_sync_q[0], word_clock_i};
         sclk_last_q <= sclk_sync_q[1];
         wclk_last_q <= wclk_sync_q[1];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic sel;
   logic wclk_rise;
   assign sclk_rise = sclk_sync_q[1] & ~sclk_last_q;
   assign sclk_fall = ~sclk_sync_q[1] & sclk_last_q;
   assign sel       = ~csn_sync_q[1];
   assign wclk_rise = wclk_sync_q[1] & ~wclk_last_q;

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [7:0] mode_a_q;
   logic [7:0] mode_b_q;
   logic [7:0] zf_en_q;
   logic       soft_reset_q;

   // read mux; reserved bits and the write-only reset bit read zero
   function automatic logic [7:0] read_reg(input logic [6:0] addr);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         DMCR_ADDR_MODE_A:  v = mode_a_q;
         DMCR_ADDR_MODE_B:  v = mode_b_q & ~(8'h01 << DMCR_B_SOFT_RESET);          // [R24]
         DMCR_ADDR_ZF_EN:   v = zf_en_q;
         DMCR_ADDR_ZF_STAT: v = {6'h00, right_zero_pin_o, left_zero_pin_o};     // [R19]
         DMCR_ADDR_DEV_ID:  v = {3'h0, PART_ID};                                // [R21]
         default:           v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // serial control word shifter
   // ------------------------------------------------------------
   logic [15:0] shift_q;
   logic [4:0]  bit_cnt_q;
   logic [7:0]  rd_shift_q;
   logic        wr_stb;
   logic [7:0]  rd_word;

   // readback byte for the header just taken; a process, so it follows the registers too
   always_comb rd_word = read_reg(shift_q[6:0]);                               // [R20]

   // word bits: [15] read/write, [14:8] address, [7:0] data
   assign wr_stb  = sclk_rise & sel & (bit_cnt_q == 5'(DMCR_WORD_BITS - 1))
                    & ~shift_q[14];                                             // [R1]

   // shift data in on rising edges, count bits within a frame
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         shift_q   <= 16'h0000;
         bit_cnt_q <= 5'h00;
      end
      else if (!sel)
      begin
         bit_cnt_q <= 5'h00;
      end
      else if (sclk_rise && bit_cnt_q != 5'(DMCR_WORD_BITS))
      begin
         shift_q   <= {shift_q[14:0], sdi_sync_q[1]};
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // readback: once header is in, load data and shift out on falling edges
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rd_shift_q    <= 8'h00;
         ctl_sdo_o     <= 1'b0;
         ctl_sdo_oen_o <= 1'b1;
      end
      else if (!sel)
      begin
         ctl_sdo_oen_o <= 1'b1;
         ctl_sdo_o     <= 1'b0;
      end
      else if (sclk_fall && bit_cnt_q == 5'h08 && shift_q[7])                  // [R1]
      begin
         rd_shift_q    <= {rd_word[6:0], 1'b0};                                 // [R20]
         ctl_sdo_o     <= rd_word[7];
         ctl_sdo_oen_o <= 1'b0;
      end
      else if (sclk_fall && bit_cnt_q > 5'h08 && !ctl_sdo_oen_o)
      begin
         ctl_sdo_o  <= rd_shift_q[7];
         rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
   end

   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   assign wr_addr = shift_q[13:7];
   assign wr_data = {shift_q[6:0], sdi_sync_q[1]};

   // register writes; soft reset returns controls to defaults
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mode_a_q <= DMCR_RST_A;                                                // [R22]
         mode_b_q <= DMCR_RST_B;
         zf_en_q  <= DMCR_RST_Z;
      end
      else if (soft_reset_q)
      begin
         mode_a_q <= DMCR_RST_A;                                                // [R9]
         mode_b_q <= DMCR_RST_B;
         zf_en_q  <= DMCR_RST_Z;
      end
      else if (wr_stb)
      begin
         // read-only addresses fall through untouched
         if (wr_addr == DMCR_ADDR_MODE_A)
            mode_a_q <= wr_data & DMCR_MASK_A;                                  // [R24]
         if (wr_addr == DMCR_ADDR_MODE_B)
            mode_b_q <= wr_data & DMCR_MASK_B & ~(8'h01 << DMCR_B_SOFT_RESET);
         if (wr_addr == DMCR_ADDR_ZF_EN)
            zf_en_q  <= wr_data & DMCR_MASK_Z;
      end
   end

   // soft reset bit is never stored: it makes a single pulse
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         soft_reset_q <= 1'b0;
      else
         soft_reset_q <= wr_stb && wr_addr == DMCR_ADDR_MODE_B
                         && wr_data[DMCR_B_SOFT_RESET];                         // [R9] [R24]
   end

   // ------------------------------------------------------------
   // attenuator step timing and soft mute ramp
   // ------------------------------------------------------------
   logic [2:0] wclk_div_q;
   logic [7:0] mute_q;
   logic       step;
   logic [2:0] rate_mask;
   assign rate_mask = 3'((4'h1 << mode_a_q[DMCR_A_ATTEN_RATE_LSB +: 2]) - 4'h1);
   assign step = wclk_rise & ((wclk_div_q & rate_mask) == 3'h0);               // [R3]

   // divide word clock by 1,2,4,8
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         wclk_div_q <= 3'h0;
      else if (wclk_rise)
         wclk_div_q <= wclk_div_q + 3'h1;
   end

   logic zero_both;
   logic zero_mute_d;
   assign zero_both   = left_zero_det_i & right_zero_det_i;
   assign zero_mute_d = mode_a_q[DMCR_A_ZERO_RUN_MUTE] & zero_both              // [R7]
                        & ~mode_b_q[DMCR_B_STREAM_MODE];                        // [R8]

   // 256-step ramp toward mute while zero-run mute holds, back up otherwise
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         mute_q <= 8'hFF;
      else if (step && zero_mute_d && mute_q != 8'h00)
         mute_q <= mute_q - 8'h01;                                              // [R23]
      else if (step && !zero_mute_d && mute_q != 8'(DMCR_MUTE_STEPS - 1))
         mute_q <= mute_q + 8'h01;
   end

   // ------------------------------------------------------------
   // registered control outputs
   // ------------------------------------------------------------
   logic flags_on;
   assign flags_on = mode_b_q[DMCR_B_STREAM_MODE]
                     ? (zf_en_q[DMCR_Z_STREAM_PAT_LSB +: 2] != 2'h0)            // [R17]
                     : zf_en_q[DMCR_Z_PCM_ENABLE];                              // [R18]

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         phase_invert_o    <= 1'b0;
         atten_step_rate_o <= 2'h0;
         atten_step_o      <= 1'b0;
         output_disable_o  <= 1'b0;
         bypass_stereo_o   <= 1'b0;
         rolloff_select_o  <= 1'b0;
         zero_mute_o       <= 1'b0;
         soft_reset_o      <= 1'b0;
         stream_mode_o     <= 1'b0;
         filter_bypass_o   <= 1'b0;
         single_channel_o  <= 1'b0;
         single_channel_mode_right_o      <= 1'b0;
         modulator_rate_o  <= 2'h0;
         zero_pins_data_o  <= 1'b0;
         left_zero_pin_o   <= 1'b0;
         right_zero_pin_o  <= 1'b0;
         mute_level_o      <= 8'hFF;
      end
      else
      begin
         phase_invert_o    <= mode_a_q[DMCR_A_PHASE_INVERT];                    // [R2]
         atten_step_rate_o <= mode_a_q[DMCR_A_ATTEN_RATE_LSB +: 2];
         atten_step_o      <= step;                                             // [R3]
         output_disable_o  <= mode_a_q[DMCR_A_OUTPUT_DISABLE];                  // [R4]
         bypass_stereo_o   <= mode_a_q[DMCR_A_BYPASS_STEREO];                   // [R5]
         rolloff_select_o  <= mode_a_q[DMCR_A_ROLLOFF];                         // [R6]
         zero_mute_o       <= zero_mute_d & (mute_q == 8'h00);                  // [R7]
         soft_reset_o      <= soft_reset_q;                                     // [R9]
         stream_mode_o     <= mode_b_q[DMCR_B_STREAM_MODE];                     // [R10]
         filter_bypass_o   <= mode_b_q[DMCR_B_FILTER_BYPASS];                   // [R11]
         single_channel_o  <= mode_b_q[DMCR_B_SINGLE_CHAN];                     // [R12]
         single_channel_mode_right_o      <= mode_b_q[DMCR_B_SINGLE_CHAN]
                              & mode_b_q[DMCR_B_SINGLE_CHANNEL_MODE_SELECT];                   // [R13]
         modulator_rate_o  <= mode_b_q[DMCR_B_MOD_RATE_LSB +: 2];               // [R14] [R16]
         zero_pins_data_o  <= mode_b_q[DMCR_B_FILTER_BYPASS]
                              & mode_a_q[DMCR_A_BYPASS_STEREO];                 // [R5]
         left_zero_pin_o   <= flags_on & left_zero_det_i;                       // [R19]
         right_zero_pin_o  <= flags_on & right_zero_det_i;
         mute_level_o      <= mute_q;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_invert;
      @(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> phase_invert_o == $past(mode_a_q[DMCR_A_PHASE_INVERT]);
   endproperty
   a_invert: assert property (p_invert) else $error("phase invert mismatch"); // [R2]

   property p_disable;
      @(posedge mclk_i) disable iff (!resetn_i)
      mode_a_q[DMCR_A_OUTPUT_DISABLE] ##1 mode_a_q[DMCR_A_OUTPUT_DISABLE] |-> output_disable_o;
   endproperty
   a_disable: assert property (p_disable) else $error("output disable lost"); // [R4]

   property p_stream_no_mute;
      @(posedge mclk_i) disable iff (!resetn_i)
      $past(mode_b_q[DMCR_B_STREAM_MODE]) |-> !zero_mute_o;
   endproperty
   a_stream_no_mute: assert property (p_stream_no_mute) else $error("mute in stream mode"); // [R8]

   sequence s_reset_write;
      wr_stb && wr_addr == DMCR_ADDR_MODE_B && wr_data[DMCR_B_SOFT_RESET];
   endsequence
   property p_reset_pulse;
      @(posedge mclk_i) disable iff (!resetn_i)
      s_reset_write |=> soft_reset_q ##1 soft_reset_o ##1 !soft_reset_o;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("soft reset pulse wrong"); // [R9]

   property p_reset_clears;
      @(posedge mclk_i) disable iff (!resetn_i)
      soft_reset_q |=> zf_en_q == DMCR_RST_Z && mode_a_q == DMCR_RST_A;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("defaults not restored"); // [R22]

   property p_single_channel_mode_sel;
      @(posedge mclk_i) disable iff (!resetn_i)
      !$past(mode_b_q[DMCR_B_SINGLE_CHAN]) |-> !single_channel_mode_right_o;
   endproperty
   a_single_channel_mode_sel: assert property (p_single_channel_mode_sel) else $error("channel select outside single_channel_mode"); // [R13]

   property p_step_rate;
      @(posedge mclk_i) disable iff (!resetn_i)
      step && mode_a_q[DMCR_A_ATTEN_RATE_LSB +: 2] == 2'h3 |-> wclk_div_q[2:0] == 3'h0;
   endproperty
   a_step_rate: assert property (p_step_rate) else $error("step rate wrong"); // [R3]

   property p_flags_off;
      @(posedge mclk_i) disable iff (!resetn_i)
      $past(!flags_on) |-> !left_zero_pin_o && !right_zero_pin_o;
   endproperty
   a_flags_off: assert property (p_flags_off) else $error("zero flag while disabled"); // [R18]

   property p_reserved;
      @(posedge mclk_i) disable iff (!resetn_i)
      (mode_a_q & ~DMCR_MASK_A) == 8'h00 && mode_b_q[7:6] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit stored"); // [R24]

   property p_ramp;
      @(posedge mclk_i) disable iff (!resetn_i)
      step && zero_mute_d && mute_q != 8'h00 |=> mute_q == $past(mute_q) - 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("mute ramp did not step"); // [R23]

endmodule

`default_nettype wire
